/* rtl/telegram_auth_pkg.sv */
// Constants, state codes and block flags for the telegram signature engine.
// Assumes one 20 MHz clock and a synchronous active-high reset.
//
// Summary of operation
// - Signature follows CCM authentication, no payload encryption
// - Length field size is always two bytes
// - Signature is always four bytes long
// - Authenticated input data never exceeds thirteen bytes
// - Sender address enters least significant byte first
// - Input carries header, counter, switch status, options
// - Default input is nine bytes, options add length
// - Two-byte input length is 9, 10, 11, 13
// - Counter starts zero, steps once per new telegram
// - Repeated transmissions reuse the same counter value
// - Counter sits little endian in bytes four to seven
// - Device holds a replaceable sixteen-byte secret key
// - Authenticated read of page 0x14 returns the key
// - Nonce is address, counter, then zero padding
// - Counter block flag 0x01, MAC block flag 0x49
// - Second MAC block is length, data, zero padding
// - Three AES-128 passes, two XORs, first four bytes
`default_nettype none
package telegram_auth_pkg;
  localparam logic [7:0] COUNTER_BLOCK_FLAG = 8'h01;
  localparam logic [7:0] MAC_BLOCK_FLAG = 8'h49;
  localparam logic [15:0] BASE_INPUT_LEN = 16'h0009;
  localparam logic [15:0] MAX_INPUT_LEN = 16'h000D;
  localparam logic [7:0] PAYLOAD_OVERHEAD = 8'h03;
  localparam logic [7:0] PAYLOAD_TYPE = 8'hFF;
  // Arbitrary neutral maker code
  localparam logic [15:0] MAKER_CODE = 16'h0A5A;
  localparam logic [7:0] KEY_PAGE = 8'h14;
  localparam logic [3:0] LAST_ROUND = 4'hA;
  localparam logic [3:0] FIRST_ROUND = 4'h1;
  localparam logic [7:0] RCON_INIT = 8'h01;
  localparam logic [7:0] SBOX_AFFINE = 8'h63;
  localparam logic [31:0] COUNTER_RESET = 32'h0000_0000;
  // Arbitrary factory key
  localparam logic [127:0] KEY_FACTORY = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_MAC0 = 4'b0010,
    ST_MAC1 = 4'b0100,
    ST_CTR = 4'b1000
  } auth_state_type;
endpackage
`default_nettype wire

/* rtl/telegram_auth_signature.sv */
// Telegram signature engine: builds the CCM blocks and runs one AES round per clock.
// Assumes request inputs come from logic on ref_clk; key and page strobes are one-cycle pulses.
`default_nettype none
module telegram_auth_signature (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [47:0] srcAddr,
  input wire logic [7:0] switchStatus,
  input wire logic [1:0] optSize,
  input wire logic [31:0] optData,
  input wire logic start,
  input wire logic newTelegram,
  input wire logic keyWr,
  input wire logic [127:0] keyWrData,
  input wire logic authOk,
  input wire logic pageRd,
  input wire logic [7:0] pageAddr,
  output logic busy,
  output logic sigValid,
  output logic [31:0] signature,
  output logic [31:0] seqCount,
  output logic pageRdAck,
  output logic [127:0] pageRdData
);
  import telegram_auth_pkg::*;

  function automatic logic [7:0] xtime(input logic [7:0] a);
    xtime = {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = xtime(x);
    end
    gmul = p;
  endfunction

  // Inverse by x^254 keeps the table out of the source at the cost of logic depth
  function automatic logic [7:0] sbox(input logic [7:0] a);
    logic [7:0] sq;
    logic [7:0] r;
    sq = a;
    r = 8'h01;
    for (int i = 0; i < 7; i++) begin
      sq = gmul(sq, sq);
      r = gmul(r, sq);
    end
    sbox = r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]} ^ {r[3:0], r[7:4]} ^ SBOX_AFFINE;
  endfunction

  function automatic logic [31:0] subWord(input logic [31:0] w);
    subWord = {sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0])};
  endfunction

  auth_state_type state_ff, nxt_state;
  logic [3:0] round_ff, nxt_round;
  logic [127:0] aesSt_ff, nxt_aesSt;
  logic [127:0] rk_ff, nxt_rk;
  logic [7:0] rcon_ff, nxt_rcon;
  logic [127:0] macOne_ff, nxt_macOne;
  logic [127:0] ctrZero_ff, nxt_ctrZero;
  logic [127:0] macPart_ff, nxt_macPart;
  logic [31:0] sig_ff, nxt_sig;
  logic sigValid_ff, nxt_sigValid;
  logic busy_ff, nxt_busy;
  logic [31:0] seqCnt_ff, nxt_seqCnt;
  logic [127:0] key_ff, nxt_key;
  logic pageAck_ff, nxt_pageAck;
  logic [127:0] pageData_ff, nxt_pageData;

  logic [7:0] sb [16];
  logic [7:0] sr [16];
  logic [127:0] roundOut;
  logic [127:0] rkNext;
  logic [31:0] kw0, kw1, kw2, kw3, kTemp;
  logic accept;
  logic [31:0] useCnt;
  logic [15:0] inputLen;
  logic [31:0] optMasked;
  logic [103:0] nonce;
  logic [103:0] inData;
  logic [127:0] macZero;

  // One AES round on the current state with the next round key
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : gSub
      assign sb[g] = sbox(aesSt_ff[127 - 8 * g -: 8]);
      assign sr[g] = sb[(((g / 4) + (g % 4)) % 4) * 4 + (g % 4)];
    end
    for (g = 0; g < 4; g++) begin : gMix
      logic [7:0] a0, a1, a2, a3;
      logic [31:0] col;
      assign a0 = sr[4 * g];
      assign a1 = sr[4 * g + 1];
      assign a2 = sr[4 * g + 2];
      assign a3 = sr[4 * g + 3];
      assign col = (round_ff == LAST_ROUND) ? {a0, a1, a2, a3} :
        {xtime(a0) ^ xtime(a1) ^ a1 ^ a2 ^ a3, a0 ^ xtime(a1) ^ xtime(a2) ^ a2 ^ a3,
         a0 ^ a1 ^ xtime(a2) ^ xtime(a3) ^ a3, xtime(a0) ^ a0 ^ a1 ^ a2 ^ xtime(a3)};
      assign roundOut[127 - 32 * g -: 32] = col ^ rkNext[127 - 32 * g -: 32];
    end
  endgenerate

  assign kTemp = subWord({rk_ff[23:0], rk_ff[31:24]}) ^ {rcon_ff, 24'h000000};
  assign kw0 = rk_ff[127:96] ^ kTemp;
  assign kw1 = rk_ff[95:64] ^ kw0;
  assign kw2 = rk_ff[63:32] ^ kw1;
  assign kw3 = rk_ff[31:0] ^ kw2;
  assign rkNext = {kw0, kw1, kw2, kw3};

  // Block assembly for a request taken this cycle
  always_comb begin
    accept = start && (state_ff == ST_IDLE);
    useCnt = newTelegram ? seqCnt_ff + 32'h0000_0001 : seqCnt_ff;
    case (optSize)
      2'b00: begin
        inputLen = BASE_INPUT_LEN;
        optMasked = 32'h0000_0000;
      end
      2'b01: begin
        inputLen = BASE_INPUT_LEN + 16'h0001;
        optMasked = {optData[7:0], 24'h000000};
      end
      2'b10: begin
        inputLen = BASE_INPUT_LEN + 16'h0002;
        optMasked = {optData[7:0], optData[15:8], 16'h0000};
      end
      default: begin
        inputLen = MAX_INPUT_LEN;
        optMasked = {optData[7:0], optData[15:8], optData[23:16], optData[31:24]};
      end
    endcase
    nonce = {srcAddr[7:0], srcAddr[15:8], srcAddr[23:16], srcAddr[31:24], srcAddr[39:32],
             srcAddr[47:40], useCnt[7:0], useCnt[15:8], useCnt[23:16], useCnt[31:24], 24'h000000};
    inData = {inputLen[7:0] + PAYLOAD_OVERHEAD, PAYLOAD_TYPE, MAKER_CODE[7:0], MAKER_CODE[15:8],
              useCnt[7:0], useCnt[15:8], useCnt[23:16], useCnt[31:24], switchStatus, optMasked};
    macZero = {MAC_BLOCK_FLAG, nonce, 16'h0000};
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_round = round_ff;
    nxt_aesSt = aesSt_ff;
    nxt_rk = rk_ff;
    nxt_rcon = rcon_ff;
    nxt_macOne = macOne_ff;
    nxt_ctrZero = ctrZero_ff;
    nxt_macPart = macPart_ff;
    nxt_sig = sig_ff;
    nxt_sigValid = 1'b0;
    nxt_busy = busy_ff;
    nxt_seqCnt = seqCnt_ff;
    case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          nxt_seqCnt = useCnt;
          nxt_macOne = {inputLen, inData, 8'h00};
          nxt_ctrZero = {COUNTER_BLOCK_FLAG, nonce, 16'h0000};
          nxt_aesSt = macZero ^ key_ff;
          nxt_rk = key_ff;
          nxt_rcon = RCON_INIT;
          nxt_round = FIRST_ROUND;
          nxt_busy = 1'b1;
          nxt_state = ST_MAC0;
        end
      end
      ST_MAC0, ST_MAC1, ST_CTR: begin
        nxt_aesSt = roundOut;
        nxt_rk = rkNext;
        nxt_rcon = xtime(rcon_ff);
        nxt_round = round_ff + 4'h1;
        if (round_ff == LAST_ROUND) begin
          nxt_rk = key_ff;
          nxt_rcon = RCON_INIT;
          nxt_round = FIRST_ROUND;
          if (state_ff == ST_MAC0) begin
            nxt_aesSt = roundOut ^ macOne_ff ^ key_ff;
            nxt_state = ST_MAC1;
          end else if (state_ff == ST_MAC1) begin
            nxt_macPart = roundOut;
            nxt_aesSt = ctrZero_ff ^ key_ff;
            nxt_state = ST_CTR;
          end else begin
            nxt_sig = macPart_ff[127:96] ^ roundOut[127:96];
            nxt_sigValid = 1'b1;
            nxt_busy = 1'b0;
            nxt_state = ST_IDLE;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_busy = 1'b0;
      end
    endcase
  end

  // Key changes are held off while a signature runs so all three passes share one key
  always_comb begin
    nxt_key = key_ff;
    nxt_pageAck = pageRd;
    nxt_pageData = 128'h0;
    if (keyWr && authOk && !busy_ff && !accept) nxt_key = keyWrData;
    if (pageRd && authOk && pageAddr == KEY_PAGE) nxt_pageData = key_ff;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      round_ff <= FIRST_ROUND;
      aesSt_ff <= 128'h0;
      rk_ff <= 128'h0;
      rcon_ff <= RCON_INIT;
      macOne_ff <= 128'h0;
      ctrZero_ff <= 128'h0;
      macPart_ff <= 128'h0;
      sig_ff <= 32'h0000_0000;
      sigValid_ff <= 1'b0;
      busy_ff <= 1'b0;
      seqCnt_ff <= COUNTER_RESET;
    end else begin
      state_ff <= nxt_state;
      round_ff <= nxt_round;
      aesSt_ff <= nxt_aesSt;
      rk_ff <= nxt_rk;
      rcon_ff <= nxt_rcon;
      macOne_ff <= nxt_macOne;
      ctrZero_ff <= nxt_ctrZero;
      macPart_ff <= nxt_macPart;
      sig_ff <= nxt_sig;
      sigValid_ff <= nxt_sigValid;
      busy_ff <= nxt_busy;
      seqCnt_ff <= nxt_seqCnt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      key_ff <= KEY_FACTORY;
      pageAck_ff <= 1'b0;
      pageData_ff <= 128'h0;
    end else begin
      key_ff <= nxt_key;
      pageAck_ff <= nxt_pageAck;
      pageData_ff <= nxt_pageData;
    end
  end

  assign busy = busy_ff;
  assign sigValid = sigValid_ff;
  assign signature = sig_ff;
  assign seqCount = seqCnt_ff;
  assign pageRdAck = pageAck_ff;
  assign pageRdData = pageData_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_taken;
    start && !busy_ff;
  endsequence
  sequence s_runs;
    busy_ff [*8] ##1 busy_ff;
  endsequence

  a_sig_latency: assert property (s_taken |-> ##31 sigValid_ff)
    else $error("signature not ready 31 cycles after start");
  a_busy_span: assert property (s_taken |=> s_runs ##1 !sigValid_ff)
    else $error("engine left busy early");
  a_counter_step: assert property (s_taken and newTelegram |=> seqCnt_ff == $past(seqCnt_ff) + 32'h0000_0001)
    else $error("counter did not step by one");
  a_repeat_same: assert property (s_taken and !newTelegram |=> $stable(seqCnt_ff))
    else $error("repeat changed the counter");
  a_input_len: assert property (busy_ff |-> macOne_ff[127:112] >= BASE_INPUT_LEN && macOne_ff[127:112] <= MAX_INPUT_LEN)
    else $error("input length out of range");
  a_counter_place: assert property (busy_ff |-> macOne_ff[79:72] == seqCnt_ff[7:0] && ctrZero_ff[71:64] == seqCnt_ff[7:0])
    else $error("counter byte misplaced");
  a_block_flags: assert property (busy_ff |-> ctrZero_ff[127:120] == COUNTER_BLOCK_FLAG && ctrZero_ff[39:0] == 40'h0)
    else $error("counter block layout wrong");
  a_src_order: assert property (s_taken |=> ctrZero_ff[119:112] == $past(srcAddr[7:0]))
    else $error("address not little endian");
  a_key_read: assert property (pageRd && authOk && pageAddr == KEY_PAGE |=> pageAck_ff && pageData_ff == $past(key_ff))
    else $error("key page read failed");
  a_key_denied: assert property (pageRd && !authOk |=> pageAck_ff && pageData_ff == 128'h0)
    else $error("key leaked without auth");
  a_sig_stable: assert property (sigValid_ff |=> $stable(sig_ff) [*2])
    else $error("signature changed after done");
endmodule
`default_nettype wire

/* verif/telegram_receiver_model.sv */
// Behavioural telegram receiver: rebuilds the CCM blocks and checks signatures.
// Assumes the shared key is known beforehand; called from the bench as a task.
`default_nettype none
module telegram_receiver_model (
  input wire logic [127:0] sharedKey
);
  timeunit 1ns;
  timeprecision 1ps;
  import telegram_auth_pkg::*;
  logic [31:0] topCount [logic [47:0]];
  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
  endfunction
  function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ a;
      a = xt(a);
    end
    return p;
  endfunction
  // Inverse by power 254: slow but needs no table
  function automatic logic [7:0] sb(input logic [7:0] x);
    logic [7:0] y;
    y = 8'h01;
    for (int i = 0; i < 254; i++) y = gm(y, x);
    return y ^ {y[6:0], y[7]} ^ {y[5:0], y[7:6]} ^ {y[4:0], y[7:5]} ^ {y[3:0], y[7:4]} ^ 8'h63;
  endfunction
  function automatic logic [127:0] enc(input logic [127:0] k, input logic [127:0] p);
    logic [7:0] s [16];
    logic [7:0] w [16];
    logic [7:0] t [16];
    logic [7:0] rc;
    logic [127:0] q;
    for (int i = 0; i < 16; i++) begin
      w[i] = k[127 - 8*i -: 8];
      s[i] = p[127 - 8*i -: 8] ^ w[i];
    end
    rc = 8'h01;
    for (int r = 1; r < 11; r++) begin
      t[0] = sb(w[13]) ^ rc;
      t[1] = sb(w[14]);
      t[2] = sb(w[15]);
      t[3] = sb(w[12]);
      for (int i = 0; i < 16; i++) w[i] = w[i] ^ ((i < 4) ? t[i] : w[i-4]);
      rc = xt(rc);
      for (int i = 0; i < 16; i++) t[i] = sb(s[(i + 4*(i%4)) % 16]);
      for (int c = 0; c < 16; c += 4) begin
        s[c] = (r < 10) ? xt(t[c]) ^ xt(t[c+1]) ^ t[c+1] ^ t[c+2] ^ t[c+3] : t[c];
        s[c+1] = (r < 10) ? t[c] ^ xt(t[c+1]) ^ xt(t[c+2]) ^ t[c+2] ^ t[c+3] : t[c+1];
        s[c+2] = (r < 10) ? t[c] ^ t[c+1] ^ xt(t[c+2]) ^ xt(t[c+3]) ^ t[c+3] : t[c+2];
        s[c+3] = (r < 10) ? xt(t[c]) ^ t[c] ^ t[c+1] ^ t[c+2] ^ xt(t[c+3]) : t[c+3];
      end
      for (int i = 0; i < 16; i++) s[i] = s[i] ^ w[i];
    end
    for (int i = 0; i < 16; i++) q[127 - 8*i -: 8] = s[i];
    return q;
  endfunction
  // Everything but the key comes from the telegram
  task automatic receive(input logic [47:0] a, input logic [103:0] d, input logic [15:0] len,
      input logic [31:0] sig, output logic ok);
    logic [103:0] nonce;
    logic [127:0] tag;
    logic [31:0] ctr;
    for (int i = 0; i < 13; i++) if (i >= len) d[103 - 8*i -: 8] = 8'h00;
    ctr = {d[47:40], d[55:48], d[63:56], d[71:64]};
    nonce = {a[7:0], a[15:8], a[23:16], a[31:24], a[39:32], a[47:40], d[71:40], 24'h0};
    tag = enc(sharedKey, {COUNTER_BLOCK_FLAG, nonce, 16'h0})
      ^ enc(sharedKey, enc(sharedKey, {MAC_BLOCK_FLAG, nonce, 16'h0}) ^ {len, d, 8'h00});
    ok = (tag[127:96] === sig) && (!topCount.exists(a) || ctr > topCount[a]);
    if (ok) topCount[a] = ctr;
  endtask
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the telegram signature engine.
// Assumes the receiver model shares the key that the bench writes.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import telegram_auth_pkg::*;
  localparam logic [127:0] TEST_KEY = 128'h5A17_C3E8_0B9D_4F26_71AE_D058_923C_B6F1;
  logic ref_clk, reset, start, newTelegram, keyWr, authOk, pageRd, busy, sigValid, pageRdAck, ok;
  logic [47:0] srcAddr;
  logic [7:0] switchStatus, pageAddr;
  logic [1:0] optSize;
  logic [31:0] optData, signature, seqCount, expCount;
  logic [127:0] keyWrData, pageRdData;
  int n_fail, checked;
  telegram_auth_signature uut (.ref_clk(ref_clk), .reset(reset), .srcAddr(srcAddr), .switchStatus(switchStatus),
    .optSize(optSize), .optData(optData), .start(start), .newTelegram(newTelegram), .keyWr(keyWr),
    .keyWrData(keyWrData), .authOk(authOk), .pageRd(pageRd), .pageAddr(pageAddr), .busy(busy),
    .sigValid(sigValid), .signature(signature), .seqCount(seqCount), .pageRdAck(pageRdAck),
    .pageRdData(pageRdData));
  telegram_receiver_model rx (.sharedKey(TEST_KEY));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic page(input logic [7:0] pg, input logic [127:0] exp);
    @(negedge ref_clk);
    pageRd = 1'b1;
    pageAddr = pg;
    @(negedge ref_clk);
    pageRd = 1'b0;
    chk("pageRdAck", 128'h1, {127'h0, pageRdAck});
    chk("pageRdData", exp, pageRdData);
  endtask
  task automatic sign(input logic [1:0] sz, input logic nt, output int lat);
    @(negedge ref_clk);
    start = 1'b1;
    optSize = sz;
    newTelegram = nt;
    @(negedge ref_clk);
    start = 1'b0;
    lat = 1;
    chk("busy", 128'h1, {127'h0, busy});
    while (sigValid !== 1'b1 && lat < 60) begin
      @(negedge ref_clk);
      lat++;
    end
  endtask
  function automatic logic [103:0] tdata(input logic [1:0] sz, input logic [31:0] c);
    logic [103:0] d;
    int n;
    n = (sz == 2'd3) ? 4 : int'(sz);
    d = {8'(12 + n), 8'hFF, MAKER_CODE[7:0], MAKER_CODE[15:8], c[7:0], c[15:8], c[23:16], c[31:24],
      switchStatus, optData[7:0], optData[15:8], optData[23:16], optData[31:24]};
    for (int i = 9 + n; i < 13; i++) d[103 - 8*i -: 8] = 8'h00;
    return d;
  endfunction
  task automatic verify(input logic [1:0] sz, input logic [31:0] sig, input logic exp);
    rx.receive(srcAddr, tdata(sz, expCount), (sz == 2'd3) ? 16'h000D : 16'(9 + sz), sig, ok);
    chk("receiver verdict", {127'h0, exp}, {127'h0, ok});
  endtask
  task automatic t_key;
    chk("reset outputs", 128'h0, {busy, sigValid, signature, seqCount, pageRdAck});
    page(KEY_PAGE, 128'h0);
    keyWrData = TEST_KEY;
    keyWr = 1'b1;
    @(negedge ref_clk);
    keyWr = 1'b0;
    authOk = 1'b1;
    page(KEY_PAGE, KEY_FACTORY);
    keyWr = 1'b1;
    @(negedge ref_clk);
    keyWr = 1'b0;
    page(KEY_PAGE, TEST_KEY);
    page(8'h13, 128'h0);
    $display("test key done");
  endtask
  task automatic t_sizes;
    int lat;
    for (int s = 0; s < 4; s++) begin
      sign(2'(s), 1'b1, lat);
      expCount++;
      chk("latency", 128'd31, 128'(lat));
      chk("seqCount", 128'(expCount), 128'(seqCount));
      verify(2'(s), signature ^ 32'h0000_0100, 1'b0);
      verify(2'(s), signature, 1'b1);
    end
    $display("test sizes done");
  endtask
  task automatic t_repeat;
    int lat;
    logic [31:0] prev;
    prev = signature;
    sign(2'd3, 1'b0, lat);
    chk("seqCount", 128'(expCount), 128'(seqCount));
    chk("signature", 128'(prev), 128'(signature));
    verify(2'd3, signature, 1'b0);
    @(negedge ref_clk);
    chk("sigValid", 128'h0, {127'h0, sigValid});
    $display("test repeat done");
  endtask
  task automatic t_busy;
    int lat;
    int extra;
    sign(2'd1, 1'b1, lat);
    expCount++;
    verify(2'd1, signature, 1'b1);
    @(negedge ref_clk);
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    repeat (5) @(negedge ref_clk);
    start = 1'b1;
    keyWr = 1'b1;
    keyWrData = ~TEST_KEY;
    @(negedge ref_clk);
    start = 1'b0;
    keyWr = 1'b0;
    extra = 0;
    repeat (60) begin
      @(negedge ref_clk);
      extra += int'(sigValid === 1'b1);
    end
    expCount++;
    chk("completions", 128'h1, 128'(extra));
    chk("seqCount", 128'(expCount), 128'(seqCount));
    page(KEY_PAGE, TEST_KEY);
    $display("test busy done");
  endtask
  initial begin
    {start, newTelegram, keyWr, authOk, pageRd} = 5'h0;
    keyWrData = 128'h0;
    reset = 1'b1;
    srcAddr = 48'hC0DE_1234_5678;
    switchStatus = 8'h11;
    optSize = 2'h0;
    optData = 32'hD4C3_B2A1;
    pageAddr = KEY_PAGE;
    expCount = 32'h0;
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    t_key;
    t_sizes;
    t_repeat;
    t_busy;
    end_sim;
  end
  // Generous limit: the whole sequence needs some 290 cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_fail++;
    $display("watchdog expired");
    end_sim;
  end
endmodule
`default_nettype wire
